// ### rtl/palette_pixel_lookup_path.sv
// Pixel lookup path of a palette video converter with its APB register port.
// Assumes clk is the pixel clock, APB runs on the same clock, and the
// frame buffer side drives pixel_in synchronously to clk.
`timescale 1ns/1ps

module palette_pixel_lookup_path (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [palette_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire palette_pkg::pixel_in_t pixel_in,
  output palette_pkg::video_out_t video_out
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Host lane word into stored 8-bit component
  function automatic logic [7:0] lane_in(input logic [31:0] d,
                                         input logic w8);
    if (w8) begin
      lane_in = d[7:0];
    end else begin
      lane_in = {d[5:0], 2'h0};
    end
  endfunction : lane_in

  // Stored component onto host lanes
  function automatic logic [31:0] lane_out(input logic [7:0] c,
                                           input logic w8);
    if (w8) begin
      lane_out = {24'h000000, c};
    end else begin
      lane_out = {26'h0000000, c[7:2]};
    end
  endfunction : lane_out

  // Pick one component of a colour word
  function automatic logic [7:0] pick(input palette_pkg::colour_t c,
                                      input palette_pkg::comp_t k);
    case (k)
      palette_pkg::COMP_RED: pick = c.r;
      palette_pkg::COMP_GREEN: pick = c.g;
      palette_pkg::COMP_BLUE: pick = c.b;
      default: pick = 8'h00;
    endcase
  endfunction : pick

  // Converter code to current above black, 0.01 mA units
  function automatic logic [11:0] scale(input logic [7:0] code);
    logic [31:0] t;
    t = {24'h000000, code} * palette_pkg::DATA_SPAN;
    t = t * palette_pkg::RECIP_255 + palette_pkg::RECIP_RND;
    scale = t[palette_pkg::RECIP_SHIFT +: 12];
  endfunction : scale

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  palette_pkg::colour_t palette_q [palette_pkg::PAL_DEPTH]; // Colour table
  palette_pkg::colour_t overlay_q [1:palette_pkg::OVL_LAST]; // Overlays
  logic [7:0] mask_q; // Pixel read mask
  logic [1:0] config_q; // Width and pedestal select
  logic [7:0] pal_addr_q; // Palette host index
  logic [3:0] ovl_addr_q; // Overlay host index
  palette_pkg::comp_t comp_q; // Component sequencer
  logic [7:0] hold_r_q; // Staged red
  logic [7:0] hold_g_q; // Staged green
  logic [31:0] prdata_q; // Read data, captured in setup phase
  logic pslverr_q; // Error answer, captured in setup phase
  palette_pkg::pixel_in_t pix_q; // Latched pixel inputs
  palette_pkg::video_out_t vout_q; // Output stage

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic setup_ph; // First cycle of a transfer
  logic access; // Completing access cycle
  logic wr; // Completing write
  logic rd; // Completing read
  logic width8; // 8-bit host colour mode
  logic ped75; // Pedestal enabled
  logic mapped; // Address hits a register
  logic ovl_hit; // Overlay index names a real register
  palette_pkg::colour_t pal_entry; // Palette word at host index
  palette_pkg::colour_t ovl_entry; // Overlay word at host index
  logic [31:0] rd_value; // Read mux result

  assign setup_ph = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign width8 = config_q[palette_pkg::CFG_WIDTH8_BIT];
  assign ped75 = config_q[palette_pkg::CFG_PED75_BIT];
  assign ovl_hit = (ovl_addr_q != 4'h0);
  assign pal_entry = palette_q[pal_addr_q];
  assign ovl_entry = ovl_hit ? overlay_q[ovl_addr_q] : '0;
  // No wait states: read data is ready from the setup phase
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // Read mux and address decode
  always_comb begin
    mapped = 1'b1;
    rd_value = 32'h0000_0000;
    case (paddr)
      palette_pkg::OFS_MASK: rd_value = {24'h000000, mask_q};
      palette_pkg::OFS_CONFIG: rd_value = {30'h00000000, config_q};
      palette_pkg::OFS_PAL_ADDR: rd_value = {24'h000000, pal_addr_q};
      palette_pkg::OFS_PAL_DATA: begin
        rd_value = lane_out(pick(pal_entry, comp_q), width8);
      end
      palette_pkg::OFS_OVL_ADDR: rd_value = {28'h0000000, ovl_addr_q};
      palette_pkg::OFS_OVL_DATA: begin
        rd_value = lane_out(pick(ovl_entry, comp_q), width8);
      end
      palette_pkg::OFS_STATUS: begin
        rd_value = {26'h0000000, pix_q.overlay_select_in == 4'h0,
                    pix_q.blank_n, pix_q.sync_n, 1'b0, comp_q};
      end
      default: mapped = 1'b0;
    endcase
  end

  // Read data and error answer, held through the access phase
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_value;
      pslverr_q <= ~mapped;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------

  // Pixel read mask, host may change it while pixels flow
  always_ff @(posedge clk) begin
    if (srst) begin
      mask_q <= palette_pkg::MASK_RESET;
    end else if (wr && paddr == palette_pkg::OFS_MASK) begin
      mask_q <= pwdata[7:0];
    end
  end

  // Width and pedestal select
  always_ff @(posedge clk) begin
    if (srst) begin
      config_q <= palette_pkg::CONFIG_RESET;
    end else if (wr && paddr == palette_pkg::OFS_CONFIG) begin
      config_q <= pwdata[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Host colour sequencing
  // ----------------------------------------------------------------------
  logic pal_port; // Access to palette colour port
  logic ovl_port; // Access to overlay colour port
  logic last_comp; // Blue cycle of a triple

  assign pal_port = access && paddr == palette_pkg::OFS_PAL_DATA;
  assign ovl_port = access && paddr == palette_pkg::OFS_OVL_DATA;
  assign last_comp = (comp_q == palette_pkg::COMP_BLUE);

  // Component sequencer: restarts on any index write
  always_ff @(posedge clk) begin
    if (srst) begin
      comp_q <= palette_pkg::COMP_RED;
    end else if (wr && (paddr == palette_pkg::OFS_PAL_ADDR ||
                        paddr == palette_pkg::OFS_OVL_ADDR)) begin
      comp_q <= palette_pkg::COMP_RED;
    end else if (pal_port || ovl_port) begin
      case (comp_q)
        palette_pkg::COMP_RED: comp_q <= palette_pkg::COMP_GREEN;
        palette_pkg::COMP_GREEN: comp_q <= palette_pkg::COMP_BLUE;
        palette_pkg::COMP_BLUE: comp_q <= palette_pkg::COMP_RED;
        default: comp_q <= palette_pkg::COMP_RED;
      endcase
    end
  end

  // Palette index: loaded by host, steps after each blue cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      pal_addr_q <= 8'h00;
    end else if (wr && paddr == palette_pkg::OFS_PAL_ADDR) begin
      pal_addr_q <= pwdata[7:0];
    end else if (pal_port && last_comp) begin
      pal_addr_q <= pal_addr_q + 8'h01; // Wraps from top to zero
    end
  end

  // Overlay index: upper index bits are dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      ovl_addr_q <= 4'h0;
    end else if (wr && paddr == palette_pkg::OFS_OVL_ADDR) begin
      ovl_addr_q <= pwdata[3:0];
    end else if (ovl_port && last_comp) begin
      ovl_addr_q <= ovl_addr_q + 4'h1;
    end
  end

  // Red and green are staged so a triple commits as one word
  always_ff @(posedge clk) begin
    if (srst) begin
      hold_r_q <= 8'h00;
      hold_g_q <= 8'h00;
    end else if (wr && (pal_port || ovl_port)) begin
      if (comp_q == palette_pkg::COMP_RED) begin
        hold_r_q <= lane_in(pwdata, width8);
      end
      if (comp_q == palette_pkg::COMP_GREEN) begin
        hold_g_q <= lane_in(pwdata, width8);
      end
    end
  end

  // Palette table: whole-word write on the blue cycle
  always_ff @(posedge clk) begin
    if (wr && pal_port && last_comp) begin
      // One-cycle 24-bit commit, pixel side sees old or new only
      palette_q[pal_addr_q] <= {hold_r_q, hold_g_q,
                                lane_in(pwdata, width8)};
    end
  end

  // Overlay table: index zero is reserved and writes to it are dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 1; i <= palette_pkg::OVL_LAST; i++) begin
        overlay_q[i] <= '0;
      end
    end else if (wr && ovl_port && last_comp && ovl_hit) begin
      overlay_q[ovl_addr_q] <= {hold_r_q, hold_g_q,
                                lane_in(pwdata, width8)};
    end
  end

  // ----------------------------------------------------------------------
  // Pixel path, stage 1: input latch
  // ----------------------------------------------------------------------

  // All pixel-side inputs share one edge to stay aligned
  always_ff @(posedge clk) begin
    if (srst) begin
      pix_q <= '{pixel_index_in: 8'h00, overlay_select_in: 4'h0,
                 sync_n: 1'b1, blank_n: 1'b0};
    end else begin
      pix_q <= pixel_in;
    end
  end

  // ----------------------------------------------------------------------
  // Pixel path, stage 2: lookup and level forming
  // ----------------------------------------------------------------------
  logic [7:0] masked_index; // Index after read mask
  palette_pkg::colour_t sel_colour; // Palette or overlay colour
  palette_pkg::colour_t dac_code; // Code after width and blank rules
  logic [11:0] black_level; // Level for code zero
  logic [2:0][11:0] chan_level; // Per channel current

  assign masked_index = pix_q.pixel_index_in & mask_q;

  // Source select and converter code forming
  always_comb begin
    if (pix_q.overlay_select_in == 4'h0) begin
      sel_colour = palette_q[masked_index];
    end else begin
      // Binary overlay number, index inputs ignored
      sel_colour = overlay_q[pix_q.overlay_select_in];
    end
    dac_code = sel_colour;
    if (!width8) begin
      dac_code.r[1:0] = 2'h0;
      dac_code.g[1:0] = 2'h0;
      dac_code.b[1:0] = 2'h0;
    end
    if (!pix_q.blank_n) begin
      dac_code = '0;
    end
  end

  // Black level from pedestal and sync; sync only subtracts
  always_comb begin
    if (ped75) begin
      black_level = pix_q.sync_n ? palette_pkg::LVL_BLACK75
                                 : palette_pkg::LVL_BLACK75_SYNC;
    end else begin
      black_level = pix_q.sync_n ? palette_pkg::LVL_BLANK
                                 : palette_pkg::LVL_ZERO;
    end
  end

  // Channel currents; blank pins outputs to the blanking level, or to zero while sync is low
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      chan_level[c] = black_level;
    end
    if (!pix_q.blank_n) begin
      for (int c = 0; c < 3; c++) begin
        chan_level[c] = pix_q.sync_n ? palette_pkg::LVL_BLANK
                                     : palette_pkg::LVL_ZERO;
      end
    end else begin
      // Sync is not masked by data: far side keeps it inside blank
      chan_level[2] = black_level + scale(dac_code.r);
      chan_level[1] = black_level + scale(dac_code.g);
      chan_level[0] = black_level + scale(dac_code.b);
    end
  end

  // Output register: colour, sync and blank leave together
  always_ff @(posedge clk) begin
    if (srst) begin
      vout_q <= '{level: {3{palette_pkg::LVL_BLANK}}, code: '0,
                  sync_n: 1'b1, blank_n: 1'b0};
    end else begin
      vout_q.level <= chan_level;
      vout_q.code <= dac_code;
      vout_q.sync_n <= pix_q.sync_n;
      vout_q.blank_n <= pix_q.blank_n;
    end
  end

  assign video_out = vout_q;

endmodule : palette_pixel_lookup_path

// ### rtl/palette_pkg.sv
// Shared constants and carrier types of the palette pixel lookup path.
// Assumes a single 25 MHz clock that serves as pixel clock and APB clock.
package palette_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8; // APB address width
  localparam logic [7:0] OFS_MASK = 8'h00; // Pixel read mask
  localparam logic [7:0] OFS_CONFIG = 8'h04; // Width and pedestal select
  localparam logic [7:0] OFS_PAL_ADDR = 8'h08; // Palette index
  localparam logic [7:0] OFS_PAL_DATA = 8'h0C; // Palette colour port
  localparam logic [7:0] OFS_OVL_ADDR = 8'h10; // Overlay index
  localparam logic [7:0] OFS_OVL_DATA = 8'h14; // Overlay colour port
  localparam logic [7:0] OFS_STATUS = 8'h18; // Read-only pixel state

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int CFG_WIDTH8_BIT = 0; // 1 = 8-bit colour, 0 = 6-bit
  localparam int CFG_PED75_BIT = 1; // 1 = 7.5 level pedestal, 0 = none
  localparam logic [7:0] MASK_RESET = 8'hFF; // All index bits pass
  localparam logic [1:0] CONFIG_RESET = 2'h0; // 6-bit, no pedestal
  localparam int PAL_DEPTH = 256; // Palette entries
  localparam int OVL_LAST = 15; // Highest overlay colour index

  // ----------------------------------------------------------------------
  // Output current levels, in units of 10 uA (0.01 mA)
  // ----------------------------------------------------------------------
  localparam logic [11:0] LVL_BLANK = 12'h2FA; // 7.62 mA
  localparam logic [11:0] LVL_ZERO = 12'h000; // 0 mA, sync tip
  localparam logic [11:0] LVL_BLACK75 = 12'h389; // 9.05 mA
  localparam logic [11:0] LVL_BLACK75_SYNC = 12'h090; // 1.44 mA
  localparam logic [31:0] DATA_SPAN = 32'h0000_06E2; // 17.62 mA full span
  localparam logic [31:0] RECIP_255 = 32'h0000_0101; // 257/65536 ~ 1/255
  localparam logic [31:0] RECIP_RND = 32'h0000_8000; // Half LSB rounding
  localparam int RECIP_SHIFT = 16; // Fraction bits of the reciprocal

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  // Colour component sequencer, Gray coded red -> green -> blue
  typedef enum logic [1:0] {
    COMP_RED = 2'b00,
    COMP_GREEN = 2'b01,
    COMP_BLUE = 2'b11
  } comp_t;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } colour_t;

  typedef struct packed {
    logic [7:0] pixel_index_in; // Frame buffer pixel index
    logic [3:0] overlay_select_in; // Overlay colour select, 0 = palette
    logic sync_n; // Composite sync, active low
    logic blank_n; // Composite blank, active low
  } pixel_in_t;

  typedef struct packed {
    logic [2:0][11:0] level; // Per channel current, r = [2]
    colour_t code; // Converter input codes
    logic sync_n; // Delayed sync, active low
    logic blank_n; // Delayed blank, active low
  } video_out_t;

endpackage : palette_pkg

// ### testbench/frame_source_model.sv
// Frame buffer and timing side model driving the pixel stream.
// Assumes the bench sets cmd just after a rising edge of clk.
`timescale 1ns/1ps

module frame_source_model #(
  parameter bit SYNC_EN = 1'b1 // Zero holds sync_n low, so sync is asserted on every pixel
) (
  input wire logic clk,
  input wire logic srst,
  input wire palette_pkg::pixel_in_t cmd,
  output palette_pkg::pixel_in_t pixel_in
);
  // Registered drive, one pixel per edge, blanked during reset
  always_ff @(posedge clk) begin
    if (srst) begin
      pixel_in <= '{8'h00, 4'h0, 1'b1, 1'b0};
    end else begin
      // Unused bits arrive as zero from cmd
      pixel_in.pixel_index_in <= cmd.pixel_index_in;
      pixel_in.overlay_select_in <= cmd.overlay_select_in;
      // Sync does not override data: send it only while blanked
      pixel_in.sync_n <= SYNC_EN
        ? (cmd.sync_n | cmd.blank_n) : 1'b0;
      pixel_in.blank_n <= cmd.blank_n;
    end
  end
endmodule : frame_source_model

// ### testbench/palette_path_assertions.sv
// Port checker of the palette pixel lookup path.
// Assumes one clock, srst synchronous active high, two-edge pixel latency.
`timescale 1ns/1ps

module palette_path_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [palette_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire palette_pkg::pixel_in_t pixel_in,
  input wire palette_pkg::video_out_t video_out
);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic [1:0] live_q; // Edges since reset, saturating
  logic [1:0] cfg_q; // Shadow of the config register
  logic [1:0] cfg_age_q; // Edges since config write, saturating
  logic cfg_wr; // A config write lands at this edge
  logic [11:0] blk; // Expected black level for the present output

  assign cfg_wr = psel && penable && pwrite
    && paddr == palette_pkg::OFS_CONFIG;
  // Black level from pedestal and delayed sync
  assign blk = cfg_q[palette_pkg::CFG_PED75_BIT]
    ? (video_out.sync_n ? palette_pkg::LVL_BLACK75
                        : palette_pkg::LVL_BLACK75_SYNC)
    : (video_out.sync_n ? palette_pkg::LVL_BLANK : palette_pkg::LVL_ZERO);

  // Earlier past values reach into reset
  always_ff @(posedge clk) begin
    if (srst) begin
      live_q <= 2'h0;
    end else if (live_q != 2'h3) begin
      live_q <= live_q + 2'h1;
    end
  end

  // Config shadow and its age; black and white level checks wait for it
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_q <= palette_pkg::CONFIG_RESET;
      cfg_age_q <= 2'h0;
    end else if (cfg_wr) begin
      cfg_q <= pwdata[1:0];
      cfg_age_q <= 2'h0;
    end else if (cfg_age_q != 2'h3) begin
      cfg_age_q <= cfg_age_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_blank_level;
    live_q == 2'h3 && !$past(pixel_in.blank_n, 2)
      && $past(pixel_in.sync_n, 2)
      |-> video_out.level == {3{palette_pkg::LVL_BLANK}};
  endproperty
  a_blank_level: assert property (p_blank_level)
    else $error("blanked pixel not at blanking level");

  property p_sync_tip;
    live_q == 2'h3 && !$past(pixel_in.blank_n, 2)
      && !$past(pixel_in.sync_n, 2) |-> video_out.level == 36'h0;
  endproperty
  a_sync_tip: assert property (p_sync_tip)
    else $error("sync tip not at zero level");

  property p_blank_code;
    live_q == 2'h3 && !$past(pixel_in.blank_n, 2)
      |-> video_out.code == 24'h0;
  endproperty
  a_blank_code: assert property (p_blank_code)
    else $error("colour passed through blanking");

  property p_latency;
    live_q == 2'h3 |-> video_out.sync_n == $past(pixel_in.sync_n, 2)
      && video_out.blank_n == $past(pixel_in.blank_n, 2);
  endproperty
  a_latency: assert property (p_latency)
    else $error("sync or blank latency wrong");

  property p_pready;
    psel |-> pready;
  endproperty
  a_pready: assert property (p_pready)
    else $error("register port stalled");

  property p_black;
    cfg_age_q == 2'h3 && video_out.blank_n && video_out.code.g == 8'h00
      |-> video_out.level[1] == blk;
  endproperty
  a_black: assert property (p_black)
    else $error("black level wrong");

  property p_white;
    cfg_age_q == 2'h3 && video_out.blank_n && video_out.code.r == 8'hFF
      |-> video_out.level[2] == blk + 12'h6E2;
  endproperty
  a_white: assert property (p_white)
    else $error("white level wrong");

  property p_rd_lanes;
    psel && penable && !pwrite && !cfg_q[palette_pkg::CFG_WIDTH8_BIT]
      && (paddr == palette_pkg::OFS_PAL_DATA
          || paddr == palette_pkg::OFS_OVL_DATA)
      |-> prdata[31:6] == 26'h0;
  endproperty
  a_rd_lanes: assert property (p_rd_lanes)
    else $error("narrow colour read drove upper lanes");
endmodule : palette_path_checker

bind palette_pixel_lookup_path palette_path_checker u_chk (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pixel_in(pixel_in),
  .video_out(video_out));

// ### testbench/palette_pixel_lookup_path_tb.sv
// Self-checking bench of the palette pixel lookup path.
// Assumes zero-wait APB and a two-edge pixel latency after the model.
`timescale 1ns/1ps

module palette_pixel_lookup_path_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr; // Register byte address
  logic [31:0] pwdata, prdata; // Register data
  palette_pkg::pixel_in_t cmd, pixel_in; // Stream request, model drive
  palette_pkg::video_out_t video_out; // Converter side result
  int err_total; // Mismatches
  int cmp_count; // Comparisons

  always #20 clk = ~clk;

  frame_source_model fb (.clk(clk), .srst(srst), .cmd(cmd),
    .pixel_in(pixel_in));
  palette_pixel_lookup_path dut (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pixel_in(pixel_in), .video_out(video_out));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [35:0] e,
                     input logic [35:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      give_verdict;
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, d, x, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask : rd

  // Index, then red, green, blue via the colour port
  task automatic wr3(input logic [7:0] i, input logic [23:0] c);
    wr(palette_pkg::OFS_PAL_ADDR, {24'h0, i});
    for (int k = 2; k >= 0; k--)
      wr(palette_pkg::OFS_PAL_DATA, {24'h0, c[k*8 +: 8]});
  endtask : wr3

  task automatic rd3(input logic [7:0] i, input logic [23:0] c);
    logic [31:0] d;
    wr(palette_pkg::OFS_PAL_ADDR, {24'h0, i});
    for (int k = 2; k >= 0; k--) begin
      rd(palette_pkg::OFS_PAL_DATA, d);
      chk("readback", {28'h0, c[k*8 +: 8]}, {4'h0, d});
    end
  endtask : rd3

  // Drive one pixel, wait until it reaches video_out
  task automatic px(input logic [7:0] i, input logic [3:0] o,
                    input logic s, input logic b);
    @(posedge clk);
    cmd <= '{i, o, s, b};
    repeat (3) @(posedge clk);
    #1;
  endtask : px

  function automatic logic [11:0] lvl(input logic [7:0] c,
                                      input logic p, input logic s);
    logic [31:0] a;
    a = ({24'h0, c} * palette_pkg::DATA_SPAN * palette_pkg::RECIP_255
         + palette_pkg::RECIP_RND) >> palette_pkg::RECIP_SHIFT;
    if (p)
      return (s ? palette_pkg::LVL_BLACK75
                : palette_pkg::LVL_BLACK75_SYNC) + a[11:0];
    return (s ? palette_pkg::LVL_BLANK : palette_pkg::LVL_ZERO) + a[11:0];
  endfunction : lvl

  task automatic chk_px(input string nm, input logic [23:0] c,
                        input logic p, input logic s);
    chk({nm, " code"}, {12'h0, c}, {12'h0, video_out.code});
    chk({nm, " level"}, {lvl(c[23:16], p, s), lvl(c[15:8], p, s),
        lvl(c[7:0], p, s)}, video_out.level);
  endtask : chk_px

  task automatic chk_bl(input string nm, input logic [11:0] v);
    chk({nm, " code"}, 36'h0, {12'h0, video_out.code});
    chk({nm, " level"}, {v, v, v}, video_out.level);
  endtask : chk_bl

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] d;
    logic e;
    #1 chk_bl("reset", palette_pkg::LVL_BLANK);
    rd(palette_pkg::OFS_MASK, d);
    chk("mask reset", 36'hFF, {4'h0, d});
    rd(palette_pkg::OFS_CONFIG, d);
    chk("config reset", 36'h0, {4'h0, d});
    apb(1'b0, 8'h40, 32'h0, d, e);
    chk("unmapped", 36'h1, {35'h0, e});
    $display("test reset done");
  endtask : t_reset

  task automatic t_wide;
    logic [31:0] d;
    wr(palette_pkg::OFS_CONFIG, 32'h1);
    wr3(8'h05, 24'hFF0080);
    px(8'h05, 4'h0, 1'b1, 1'b1);
    chk_px("wide", 24'hFF0080, 1'b0, 1'b1);
    rd3(8'h05, 24'hFF0080);
    // Index 7 masked to entry 5
    wr(palette_pkg::OFS_MASK, 32'hFD);
    rd(palette_pkg::OFS_MASK, d);
    chk("mask", 36'hFD, {4'h0, d});
    px(8'h07, 4'h0, 1'b1, 1'b1);
    chk_px("masked", 24'hFF0080, 1'b0, 1'b1);
    wr(palette_pkg::OFS_MASK, 32'hFF);
    $display("test wide done");
  endtask : t_wide

  task automatic t_narrow;
    wr(palette_pkg::OFS_CONFIG, 32'h0);
    wr3(8'h06, 24'hFFC13F);
    px(8'h06, 4'h0, 1'b1, 1'b1);
    chk_px("narrow", 24'hFC04FC, 1'b0, 1'b1);
    rd3(8'h06, 24'h3F013F);
    // Red and green only: the entry must stay whole
    wr(palette_pkg::OFS_PAL_ADDR, 32'h6);
    wr(palette_pkg::OFS_PAL_DATA, 32'h0);
    wr(palette_pkg::OFS_PAL_DATA, 32'h0);
    px(8'h06, 4'h0, 1'b1, 1'b1);
    chk_px("partial", 24'hFC04FC, 1'b0, 1'b1);
    $display("test narrow done");
  endtask : t_narrow

  task automatic t_overlay;
    logic [3:0] v;
    wr(palette_pkg::OFS_CONFIG, 32'h1);
    wr(palette_pkg::OFS_OVL_ADDR, 32'h1);
    for (int i = 1; i <= 15; i++) begin
      v = i[3:0];
      wr(palette_pkg::OFS_OVL_DATA, {24'h0, v, v});
      wr(palette_pkg::OFS_OVL_DATA, {24'h0, ~v, v});
      wr(palette_pkg::OFS_OVL_DATA, {28'h0, v});
    end
    for (int i = 1; i <= 15; i++) begin
      v = i[3:0];
      px(8'h05, v, 1'b1, 1'b1);
      chk_px("overlay", {v, v, ~v, v, 4'h0, v}, 1'b0, 1'b1);
    end
    $display("test overlay done");
  endtask : t_overlay

  task automatic t_levels;
    px(8'h05, 4'h0, 1'b1, 1'b0);
    wr(palette_pkg::OFS_CONFIG, 32'h3);
    px(8'h05, 4'h0, 1'b1, 1'b0);
    chk_bl("blank", palette_pkg::LVL_BLANK);
    px(8'h05, 4'h0, 1'b0, 1'b0);
    chk_bl("sync tip", palette_pkg::LVL_ZERO);
    px(8'h05, 4'h0, 1'b1, 1'b1);
    chk_px("pedestal", 24'hFF0080, 1'b1, 1'b1);
    px(8'h05, 4'h0, 1'b0, 1'b1);
    chk("sync held", 36'h1, {35'h0, video_out.sync_n});
    $display("test levels done");
  endtask : t_levels

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cmd = '{8'h00, 4'h0, 1'b1, 1'b0};
    err_total = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_wide;
    t_narrow;
    t_overlay;
    t_levels;
    give_verdict;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict;
  end
endmodule : palette_pixel_lookup_path_tb
